//--- shared/uart_pkg.sv
package uart_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h30;
    localparam logic [7:0] ADDR_STAT = 8'h31;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h32;
    localparam logic [7:0] ADDR_BAUD_LO = 8'h33;
    localparam logic [7:0] ADDR_DATA = 8'h34;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h35;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h36;
    localparam int CTL_TX_EN = 7;
    localparam int CTL_RX_EN = 5;
    localparam int CTL_PAR_EN = 4;
    localparam int CTL_PAR_SEL = 3;
    localparam int CTL_STOP_SEL = 2;
    localparam int CTL_CHAR_SEL = 1;
    localparam int ST_OVR = 5;
    localparam int EV_RXF = 0;
    localparam int EV_TXE = 1;
    localparam int EV_OVR = 2;
    localparam int EV_PAR = 3;
    localparam int EV_FRM = 4;
    localparam int EV_W = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] BAUD_RESET = 16'h0043;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;

    // Parity bit for a character; seven-bit mode ignores bit 7
    function automatic logic par_bit(input logic [7:0] d, input logic seven,
                                     input logic even);
        logic p;
        p = ^(seven ? {1'b0, d[6:0]} : d);
        return even ? p : ~p;
    endfunction

    function automatic logic [2:0] last_idx(input logic seven);
        return seven ? 3'h6 : 3'h7;
    endfunction
endpackage

//--- rtl/uart_tx_shift.sv
`timescale 1ns/1ps
module uart_tx_shift (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tick,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_par_en,
    input wire logic i_par_sel,
    input wire logic i_stop_sel,
    input wire logic i_char_sel,
    output logic o_ready,
    output logic o_txd
);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
    typedef struct packed {
        tx_state_e st;
        logic [3:0] ovs;
        logic [2:0] idx;
        logic [7:0] dat;
        logic pen;
        logic psel;
        logic stop2;
        logic seven;
        logic txd;
    } tx_s;
    tx_s q;
    tx_s n;

    assign o_ready = (q.st == TX_IDLE);
    assign o_txd = q.txd;

    always_comb begin
        n = q;
        unique case (q.st)
            TX_IDLE: begin
                if (i_valid) begin
                    // Format is frozen per frame so a control write cannot garble it
                    n.st = TX_START;
                    n.ovs = '0;
                    n.dat = i_data;
                    n.pen = i_par_en;
                    n.psel = i_par_sel;
                    n.stop2 = i_stop_sel;
                    n.seven = i_char_sel;
                    n.txd = 1'b0;
                end
            end
            default: begin
                if (i_tick) begin
                    n.ovs = q.ovs + 4'h1;
                    if (q.ovs == uart_pkg::OVS_LAST) begin
                        unique case (q.st)
                            TX_START: begin
                                n.st = TX_DATA;
                                n.idx = '0;
                                n.txd = q.dat[0];
                            end
                            TX_DATA: begin
                                if (q.idx == uart_pkg::last_idx(q.seven)) begin
                                    n.idx = '0;
                                    n.st = q.pen ? TX_PAR : TX_STOP;
                                    n.txd = q.pen ? uart_pkg::par_bit(q.dat, q.seven, q.psel) : 1'b1;
                                end else begin
                                    n.idx = q.idx + 3'h1;
                                    n.txd = q.dat[q.idx + 3'h1];
                                end
                            end
                            TX_PAR: begin
                                n.st = TX_STOP;
                                n.txd = 1'b1;
                            end
                            default: begin
                                if (q.stop2 && q.idx == 3'h0) begin
                                    n.idx = 3'h1;
                                end else begin
                                    n.st = TX_IDLE;
                                end
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '{st: TX_IDLE, txd: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    par_gate_a: assert property ($changed(q.st) && $past(q.st) == TX_DATA |->
        (q.st == TX_PAR) == q.pen) else $error("parity bit presence wrong");
    par_sense_a: assert property (q.st == TX_PAR |->
        ((^(q.seven ? {1'b0, q.dat[6:0]} : q.dat)) ^ o_txd) == !q.psel)
        else $error("parity sense wrong");
    char_len_a: assert property (q.st == TX_DATA && n.st != TX_DATA |->
        q.idx == (q.seven ? 3'h6 : 3'h7)) else $error("character length wrong");
    stop_len_a: assert property (q.st == TX_STOP && n.st == TX_IDLE |->
        q.idx == {2'b00, q.stop2}) else $error("stop length wrong");
endmodule

//--- rtl/uart_rx_shift.sv
`timescale 1ns/1ps
module uart_rx_shift (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tick,
    input wire logic i_enable,
    input wire logic i_rxd,
    input wire logic i_par_en,
    input wire logic i_par_sel,
    input wire logic i_stop_sel,
    input wire logic i_char_sel,
    output logic o_done,
    output logic [7:0] o_data,
    output logic o_par_err,
    output logic o_frm_err
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
    typedef struct packed {
        rx_state_e st;
        logic [3:0] ovs;
        logic [2:0] idx;
        logic [7:0] dat;
        logic perr;
        logic ferr;
        logic done;
        logic pen;
        logic psel;
        logic stop2;
        logic seven;
    } rx_s;
    rx_s q;
    rx_s n;
    logic samp;

    assign o_done = q.done;
    assign o_data = q.dat;
    assign o_par_err = q.perr;
    assign o_frm_err = q.ferr;
    assign samp = i_tick && q.ovs == uart_pkg::OVS_LAST;

    always_comb begin
        n = q;
        n.done = 1'b0;
        if (q.st == RX_IDLE) begin
            if (i_enable && !i_rxd) begin
                n = '{st: RX_START, pen: i_par_en, psel: i_par_sel, stop2: i_stop_sel,
                      seven: i_char_sel, default: '0};
            end
        end else if (!i_enable) begin
            n.st = RX_IDLE;
        end else if (i_tick) begin
            n.ovs = q.ovs + 4'h1;
            if (q.st == RX_START && q.ovs == uart_pkg::OVS_MID) begin
                // Realign so later samples land mid-bit; a short glitch is dropped
                n.ovs = '0;
                n.st = i_rxd ? RX_IDLE : RX_DATA;
            end else if (samp) begin
                unique case (q.st)
                    RX_DATA: begin
                        n.dat[q.idx] = i_rxd;
                        n.idx = q.idx + 3'h1;
                        if (q.idx == uart_pkg::last_idx(q.seven)) begin
                            n.idx = '0;
                            n.st = q.pen ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        n.perr = i_rxd != uart_pkg::par_bit(q.dat, q.seven, q.psel);
                        n.st = RX_STOP;
                    end
                    RX_STOP: begin
                        n.ferr = q.ferr | !i_rxd;
                        if (q.stop2 && q.idx == 3'h0) begin
                            n.idx = 3'h1;
                        end else begin
                            n.done = 1'b1;
                            n.st = RX_IDLE;
                        end
                    end
                    default: n.st = q.st;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '{st: RX_IDLE, default: '0};
        end else begin
            q <= n;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    frm_catch_a: assert property (q.st == RX_STOP && samp && i_enable && !i_rxd |=>
        o_frm_err) else $error("low stop bit not flagged");
    rx_seven_a: assert property (o_done && q.seven |-> !o_data[7])
        else $error("seven-bit character has bit 7 set");
endmodule

//--- rtl/uart_frame_and_status.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Operation
// - Parity bit present only when parity enabled
// - Parity select: zero odd, one even
// - Stop select: one or two stop bits
// - Char select: eight or seven data bits
// - Control bit 0 is plain user storage
// - Status bit 7: buffered character parity error
// - Status bit 6: buffered character framing error
// - Overrun sticky until software writes one
// - Status bits 4 to 2 read zero
// - Receive full sets, interrupts, read clears
// - Transmit full flag; empty raises interrupt
// - Status register zero after reset
// - Control bits 7 and 5 enable directions
// - One data address: write transmit, read receive
// - Control register resets to zero
module uart_frame_and_status (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [7:0] o_rdata,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] baud;
        logic [15:0] bcnt;
        logic tick;
        logic [7:0] txb;
        logic txf;
        logic [7:0] rxb;
        logic rxf;
        logic perr;
        logic ferr;
        logic ovr;
        logic [uart_pkg::EV_W-1:0] ist;
        logic [uart_pkg::EV_W-1:0] imsk;
        logic [7:0] rdata;
    } ctl_s;

    ctl_s q;
    ctl_s n;
    logic [uart_pkg::EV_W-1:0] ev;
    logic tx_valid;
    logic tx_ready;
    logic tx_take;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    logic rd_data;
    logic wr_data;
    logic wr_stat;

    assign tx_valid = q.txf && q.ctrl[uart_pkg::CTL_TX_EN];
    assign tx_take = tx_valid && tx_ready;
    assign rd_data = i_rd_stb && i_addr == uart_pkg::ADDR_DATA;
    assign wr_data = i_wr_stb && i_addr == uart_pkg::ADDR_DATA;
    assign wr_stat = i_wr_stb && i_addr == uart_pkg::ADDR_STAT;

    uart_tx_shift u_tx (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(q.tick),
        .i_valid(tx_valid),
        .i_data(q.txb),
        .i_par_en(q.ctrl[uart_pkg::CTL_PAR_EN]),
        .i_par_sel(q.ctrl[uart_pkg::CTL_PAR_SEL]),
        .i_stop_sel(q.ctrl[uart_pkg::CTL_STOP_SEL]),
        .i_char_sel(q.ctrl[uart_pkg::CTL_CHAR_SEL]),
        .o_ready(tx_ready),
        .o_txd(o_txd)
    );

    uart_rx_shift u_rx (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(q.tick),
        .i_enable(q.ctrl[uart_pkg::CTL_RX_EN]),
        .i_rxd(i_rxd),
        .i_par_en(q.ctrl[uart_pkg::CTL_PAR_EN]),
        .i_par_sel(q.ctrl[uart_pkg::CTL_PAR_SEL]),
        .i_stop_sel(q.ctrl[uart_pkg::CTL_STOP_SEL]),
        .i_char_sel(q.ctrl[uart_pkg::CTL_CHAR_SEL]),
        .o_done(rx_done),
        .o_data(rx_data),
        .o_par_err(rx_perr),
        .o_frm_err(rx_ferr)
    );

    always_comb begin
        n = q;
        ev = '0;
        n.rdata = '0;
        n.tick = 1'b0;

        // Oversampling tick at sixteen times the bit rate
        if (q.bcnt >= q.baud) begin
            n.bcnt = '0;
            n.tick = 1'b1;
        end else begin
            n.bcnt = q.bcnt + 16'h1;
        end

        // Shifter took the buffered byte: buffer empty again
        if (tx_take) begin
            n.txf = 1'b0;
            ev[uart_pkg::EV_TXE] = 1'b1;
        end

        if (i_wr_stb) begin
            case (i_addr)
                uart_pkg::ADDR_CTRL: begin
                    n.ctrl = i_wdata;
                end
                uart_pkg::ADDR_STAT: begin
                    if (i_wdata[uart_pkg::ST_OVR]) begin
                        n.ovr = 1'b0;
                    end
                end
                uart_pkg::ADDR_BAUD_HI: begin
                    n.baud[15:8] = i_wdata;
                end
                uart_pkg::ADDR_BAUD_LO: begin
                    n.baud[7:0] = i_wdata;
                end
                uart_pkg::ADDR_DATA: begin
                    // A write while full is dropped rather than clobbering the queued byte
                    if (!q.txf) begin
                        n.txb = i_wdata;
                        n.txf = 1'b1;
                    end
                end
                uart_pkg::ADDR_IRQ_STAT: begin
                    n.ist = q.ist & ~i_wdata[uart_pkg::EV_W-1:0];
                end
                uart_pkg::ADDR_IRQ_MASK: begin
                    n.imsk = i_wdata[uart_pkg::EV_W-1:0];
                end
                default: begin
                    n.ctrl = q.ctrl;
                end
            endcase
        end

        if (i_rd_stb) begin
            case (i_addr)
                uart_pkg::ADDR_CTRL: begin
                    n.rdata = q.ctrl;
                end
                uart_pkg::ADDR_STAT: begin
                    n.rdata = {q.perr, q.ferr, q.ovr, 3'h0, q.rxf, q.txf};
                end
                uart_pkg::ADDR_BAUD_HI: begin
                    n.rdata = q.baud[15:8];
                end
                uart_pkg::ADDR_BAUD_LO: begin
                    n.rdata = q.baud[7:0];
                end
                uart_pkg::ADDR_DATA: begin
                    n.rdata = q.rxb;
                    n.rxf = 1'b0;
                end
                uart_pkg::ADDR_IRQ_STAT: begin
                    n.rdata = {3'h0, q.ist};
                end
                uart_pkg::ADDR_IRQ_MASK: begin
                    n.rdata = {3'h0, q.imsk};
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end

        // Receive after the bus so a landing character beats a same-cycle clear
        if (rx_done) begin
            if (q.rxf && !rd_data) begin
                n.ovr = 1'b1;
                ev[uart_pkg::EV_OVR] = 1'b1;
            end else begin
                n.rxb = rx_data;
                n.rxf = 1'b1;
                n.perr = rx_perr;
                n.ferr = rx_ferr;
                ev[uart_pkg::EV_RXF] = 1'b1;
                ev[uart_pkg::EV_PAR] = rx_perr;
                ev[uart_pkg::EV_FRM] = rx_ferr;
            end
        end

        n.ist = n.ist | ev;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '{ctrl: uart_pkg::CTRL_RESET, baud: uart_pkg::BAUD_RESET, default: '0};
        end else begin
            q <= n;
        end
    end

    assign o_rdata = q.rdata;
    // Level interrupt: any unmasked sticky event holds it high
    assign o_irq = |(q.ist & q.imsk);

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_rx_land;
        rx_done && !(q.rxf && !rd_data);
    endsequence

    sequence s_rx_clash;
        rx_done && q.rxf && !rd_data;
    endsequence

    ctrl_reset_a: assert property ($fell(i_sys_rst) |-> q.ctrl == 8'h00)
        else $error("control not zero after reset");
    stat_reset_a: assert property ($fell(i_sys_rst) |->
        !q.perr && !q.ferr && !q.ovr && !q.rxf && !q.txf) else $error("status not zero");
    rsv_zero_a: assert property (i_rd_stb && i_addr == uart_pkg::ADDR_STAT |=>
        o_rdata[4:2] == 3'h0 && o_rdata[1] == $past(q.rxf)) else $error("status read wrong");
    ovr_hold_a: assert property (q.ovr && !(wr_stat && i_wdata[5]) |=> q.ovr)
        else $error("overrun dropped without clear");
    ovr_clear_a: assert property (wr_stat && i_wdata[5] && !rx_done |=> !q.ovr)
        else $error("overrun not cleared");
    no_clobber_a: assert property (s_rx_clash |=> q.ovr && $stable(q.rxb))
        else $error("unread byte overwritten");
    rx_land_a: assert property (s_rx_land |=> q.rxf && q.ist[0] &&
        q.rxb == $past(rx_data) && q.perr == $past(rx_perr) && q.ferr == $past(rx_ferr))
        else $error("received byte not buffered");
    rx_read_a: assert property (rd_data && !rx_done |=> !q.rxf &&
        o_rdata == $past(q.rxb)) else $error("data read wrong");
    tx_gate_a: assert property (tx_take |-> q.ctrl[7])
        else $error("transmit while disabled");
    tx_empty_a: assert property ($fell(q.txf) |-> q.ist[1])
        else $error("no empty event");
    user_bit_a: assert property (i_wr_stb && i_addr == uart_pkg::ADDR_CTRL
        ##1 i_rd_stb && i_addr == uart_pkg::ADDR_CTRL |=> o_rdata[0] == $past(i_wdata[0], 2))
        else $error("user bit lost");
endmodule

//--- testbench/uart_peer_model.sv
`timescale 1ns/1ps
module uart_peer_model (
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd
);
    int cyc = 0;
    int last_start = 0;

    initial o_rxd = 1'b1;

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
    end

    // Sixteen clocks per bit, baud divisor is zero
    task automatic put_bit(input logic b);
        o_rxd <= b;
        repeat (16) @(posedge i_clk);
    endtask

    task automatic send(input logic [7:0] d, input int nb, input bit pe, input logic pv,
                        input int ns, input logic sv);
        put_bit(1'b0);
        for (int i = 0; i < nb; i++) put_bit(d[i]);
        if (pe) put_bit(pv);
        for (int i = 0; i < ns; i++) put_bit(sv);
        o_rxd <= 1'b1;
    endtask

    // Samples mid-bit; gap is start-to-start distance in clocks
    task automatic recv(input int nb, input bit pe, input int ns, output logic [7:0] d,
                        output logic pb, output logic st, output int gap);
        d = 8'h00;
        pb = 1'b0;
        st = 1'b1;
        while (i_txd !== 1'b0) @(posedge i_clk);
        gap = cyc - last_start;
        last_start = cyc;
        repeat (8) @(posedge i_clk);
        for (int i = 0; i < nb; i++) begin
            repeat (16) @(posedge i_clk);
            d[i] = i_txd;
        end
        if (pe) begin
            repeat (16) @(posedge i_clk);
            pb = i_txd;
        end
        for (int i = 0; i < ns; i++) begin
            repeat (16) @(posedge i_clk);
            st &= i_txd;
        end
    endtask
endmodule

//--- testbench/uart_frame_and_status_tb.sv
`timescale 1ns/1ps
module uart_frame_and_status_tb;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr_stb = 1'b0;
    logic i_rd_stb = 1'b0;
    logic [7:0] o_rdata;
    logic rxd;
    logic o_txd;
    logic o_irq;
    int mismatches = 0;
    int comparisons = 0;

    always #4 i_clk = ~i_clk;

    uart_frame_and_status uart_frame_and_status_i (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr_stb(i_wr_stb),
        .i_rd_stb(i_rd_stb),
        .o_rdata(o_rdata),
        .i_rxd(rxd),
        .o_txd(o_txd),
        .o_irq(o_irq)
    );

    uart_peer_model uart_peer_model_i (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr_stb <= 1'b1;
        @(posedge i_clk);
        i_wr_stb <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_clk);
        i_rd_stb <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk_byte(v, exp);
    endtask

    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge i_clk);
        #1 chk_bit(o_irq, exp);
    endtask

    task automatic wait_flag(input int b, input logic v);
        logic [7:0] s;
        s = {8{~v}};
        for (int n = 0; n < 60 && s[b] !== v; n++) rd(uart_pkg::ADDR_STAT, s);
        chk_bit(s[b], v);
    endtask

    function automatic logic exp_par(input logic [7:0] d, input int nb, input bit even);
        logic p;
        p = 1'b0;
        for (int i = 0; i < nb; i++) p ^= d[i];
        return even ? p : ~p;
    endfunction

    // Two frames back to back; second start must follow the first frame's end
    task automatic tx_pair(input logic [7:0] d0, input logic [7:0] d1, input int nb,
                           input bit pe, input bit ev, input int ns);
        logic [7:0] got;
        logic pb;
        logic st;
        int gap;
        int flen;
        flen = 16 * (1 + nb + pe + ns);
        fork
            begin
                uart_peer_model_i.recv(nb, pe, ns, got, pb, st, gap);
                chk_byte(got, d0 & (nb == 7 ? 8'h7f : 8'hff));
                if (pe) chk_bit(pb, exp_par(d0, nb, ev));
                chk_bit(st, 1'b1);
                uart_peer_model_i.recv(nb, pe, ns, got, pb, st, gap);
                chk_byte(got, d1 & (nb == 7 ? 8'h7f : 8'hff));
                chk_bit(gap >= flen && gap <= flen + 3, 1'b1);
            end
            begin
                wr(uart_pkg::ADDR_DATA, d0);
                wait_flag(0, 1'b0);
                wr(uart_pkg::ADDR_DATA, d1);
            end
        join
    endtask

    initial begin
        repeat (40000) @(posedge i_clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] v;
        logic pb;
        logic st;
        int gap;
        int nb;
        int ns;
        bit pe;
        bit ev;
        void'($urandom(32'hec8b7900));
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1 chk_bit(o_txd, 1'b1);
        chk_reg(uart_pkg::ADDR_CTRL, 8'h00);
        chk_reg(uart_pkg::ADDR_STAT, 8'h00);
        chk_bit(o_irq, 1'b0);
        wr(uart_pkg::ADDR_CTRL, 8'h01);
        chk_reg(uart_pkg::ADDR_CTRL, 8'h01);
        wr(8'h3f, 8'ha5);
        chk_reg(8'h3f, 8'h00);
        wr(uart_pkg::ADDR_BAUD_HI, 8'h00);
        wr(uart_pkg::ADDR_BAUD_LO, 8'h00);
        for (int k = 0; k < 16; k++) begin
            pe = k[3];
            ev = k[2];
            ns = k[1] ? 2 : 1;
            nb = k[0] ? 7 : 8;
            d0 = (k == 0) ? 8'h00 : 8'($urandom);
            d1 = (k == 0) ? 8'hff : 8'($urandom);
            wr(uart_pkg::ADDR_CTRL, {3'h5, k[3:0], 1'b1});
            chk_reg(uart_pkg::ADDR_CTRL, {3'h5, k[3:0], 1'b1});
            tx_pair(d0, d1, nb, pe, ev, ns);
            uart_peer_model_i.send(d1, nb, pe, exp_par(d1, nb, ev), ns, 1'b1);
            wait_flag(1, 1'b1);
            chk_reg(uart_pkg::ADDR_STAT, 8'h02);
            chk_reg(uart_pkg::ADDR_DATA, d1 & (nb == 7 ? 8'h7f : 8'hff));
            chk_reg(uart_pkg::ADDR_STAT, 8'h00);
        end
        // Parity on, even, one stop, eight bits
        wr(uart_pkg::ADDR_CTRL, 8'hb8);
        wr(uart_pkg::ADDR_IRQ_STAT, 8'h1f);
        wr(uart_pkg::ADDR_IRQ_MASK, 8'h01);
        chk_irq(1'b0);
        d0 = 8'($urandom);
        uart_peer_model_i.send(d0, 8, 1, exp_par(d0, 8, 1), 1, 1'b1);
        wait_flag(1, 1'b1);
        chk_irq(1'b1);
        chk_reg(uart_pkg::ADDR_IRQ_STAT, 8'h01);
        wr(uart_pkg::ADDR_IRQ_MASK, 8'h00);
        chk_irq(1'b0);
        wr(uart_pkg::ADDR_IRQ_MASK, 8'h01);
        wr(uart_pkg::ADDR_IRQ_STAT, 8'h01);
        chk_irq(1'b0);
        // Second byte while the first is unread
        uart_peer_model_i.send(~d0, 8, 1, exp_par(~d0, 8, 1), 1, 1'b1);
        wait_flag(5, 1'b1);
        chk_reg(uart_pkg::ADDR_STAT, 8'h22);
        rd(uart_pkg::ADDR_IRQ_STAT, v);
        chk_bit(v[2], 1'b1);
        wr(uart_pkg::ADDR_STAT, 8'h00);
        chk_reg(uart_pkg::ADDR_STAT, 8'h22);
        wr(uart_pkg::ADDR_STAT, 8'h20);
        chk_reg(uart_pkg::ADDR_STAT, 8'h02);
        chk_reg(uart_pkg::ADDR_DATA, d0);
        uart_peer_model_i.send(d0, 8, 1, ~exp_par(d0, 8, 1), 1, 1'b1);
        wait_flag(1, 1'b1);
        chk_reg(uart_pkg::ADDR_STAT, 8'h82);
        chk_reg(uart_pkg::ADDR_DATA, d0);
        uart_peer_model_i.send(d0, 8, 1, exp_par(d0, 8, 1), 1, 1'b0);
        wait_flag(1, 1'b1);
        chk_reg(uart_pkg::ADDR_STAT, 8'h42);
        chk_reg(uart_pkg::ADDR_DATA, d0);
        repeat (32) @(posedge i_clk);
        // Transmit held back until enabled
        wr(uart_pkg::ADDR_CTRL, 8'h38);
        wr(uart_pkg::ADDR_DATA, d0);
        repeat (40) @(posedge i_clk);
        #1 chk_bit(o_txd, 1'b1);
        wait_flag(0, 1'b1);
        wr(uart_pkg::ADDR_IRQ_STAT, 8'h1f);
        wr(uart_pkg::ADDR_IRQ_MASK, 8'h02);
        chk_irq(1'b0);
        wr(uart_pkg::ADDR_CTRL, 8'hb8);
        chk_irq(1'b1);
        // Held byte leaves as soon as enabled; drain it before the next pair
        uart_peer_model_i.recv(8, 1, 1, v, pb, st, gap);
        chk_byte(v, d0);
        tx_pair(d0, ~d0, 8, 1, 1, 1);
        // Receive off: frame ignored
        wr(uart_pkg::ADDR_CTRL, 8'h98);
        uart_peer_model_i.send(d0, 8, 1, exp_par(d0, 8, 1), 1, 1'b1);
        repeat (8) @(posedge i_clk);
        // Framing flag of the last landed character stays; nothing new lands
        chk_reg(uart_pkg::ADDR_STAT, 8'h40);
        print_verdict();
    end
endmodule
